// >>> hdl/csc_pkg.sv
`default_nettype none
package csc_pkg;
	// Register byte offsets
	localparam logic [7:0] CSC_ADR_CTRL = 8'h00;
	localparam logic [7:0] CSC_ADR_TUNE = 8'h04;
	localparam logic [7:0] CSC_ADR_BAUD = 8'h08;
	localparam logic [7:0] CSC_ADR_STAT = 8'h0c;
	localparam logic [7:0] CSC_ADR_MASK = 8'h10;
	localparam logic [7:0] CSC_ADR_MON = 8'h14;
	localparam logic [7:0] CSC_ADR_WORD = 8'h18;
	localparam logic [7:0] CSC_ADR_RATIO = 8'h1c;
	// Control bits
	localparam int CSC_CTRL_CLKEN = 0;
	localparam int CSC_CTRL_SUPEN = 1;
	localparam int CSC_CTRL_ANAEN = 2;
	localparam int CSC_CTRL_BAND315 = 3;
	localparam int CSC_CTRL_OFFCMD = 4;
	localparam logic [3:0] CSC_CTRL_RESET = 4'h3;
	// Status and mask bits
	localparam int CSC_ST_WAKE = 0;
	localparam int CSC_ST_OSCGOOD = 1;
	localparam int CSC_ST_LOWBATT = 2;
	localparam int CSC_ST_SUPLOST = 3;
	// Tuning
	localparam logic [8:0] CSC_TUNE_RESET = 9'h0dd;
	localparam logic [11:0] CSC_TUNE_BASE = 12'he00;
	localparam logic [11:0] CSC_TUNE_MIN = 12'hedb;
	localparam logic [11:0] CSC_TUNE_MAX = 12'hfd5;
	localparam int CSC_LOW_BITS = 5;
	// Band multipliers doubled, ratio in units of 1/32768
	localparam logic [7:0] CSC_MULT2_433 = 8'h41;
	localparam logic [7:0] CSC_MULT2_868 = 8'h81;
	localparam logic [7:0] CSC_MULT2_315 = 8'h31;
	localparam logic [21:0] CSC_RATIO_OFS = 22'h000029;
	// Dividers: ref_clk runs at twice the crystal rate
	localparam int CSC_REF_PER_XTAL = 2;
	localparam int CSC_CLK_DIV = 3;
	localparam int CSC_BASE_DIV = 16;
	localparam logic [7:0] CSC_CLK_HALF_LIM =
		8'((CSC_CLK_DIV * CSC_REF_PER_XTAL) / 2 - 1);
	localparam logic [7:0] CSC_BASE_LIM =
		8'(CSC_BASE_DIV * CSC_REF_PER_XTAL - 1);
	localparam logic [1:0] CSC_STRAP_WAIT = 2'h3;
	typedef enum logic [0:0] {
		CSC_OFF = 1'b0,
		CSC_IDLE = 1'b1
	} csc_mode_e;
endpackage
`default_nettype wire

// >>> hdl/csc_sync.sv
`default_nettype none
module csc_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// Levels
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_r;

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule
`default_nettype wire

// >>> hdl/csc_divider.sv
`default_nettype none
module csc_divider (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// Control
	input wire logic hold,
	input wire logic advance,
	input wire logic [7:0] limit,
	// Enable pulse
	output logic tick
);
	logic [7:0] count_r;
	wire atLimit = (count_r >= limit);

	always_ff @(posedge ref_clk) begin
		if (!reset_n || hold) begin
			count_r <= 8'h00;
			tick <= 1'b0;
		end else begin
			tick <= advance & atLimit;
			if (advance)
				count_r <= atLimit ? 8'h00 : 8'(count_r + 8'h01);
		end
	end
endmodule
`default_nettype wire

// >>> hdl/csc_clock_supply.sv
// Contract
// - RF ratio is band multiplier plus (word+20.5)/16384
// - Tuning word is 3584 plus two partial values
// - Controller clock output is crystal divided by three
// - First clock output period may be short
// - Controller clock has 50 percent duty
// - Base clock is crystal divided by sixteen
// - Bit-check and baud timed from base clock
// - Bit-check period set by range field, baud period by limit field
// - Controller reset low while supply output low
// - Power-on input high wakes the device
// - Any button input low wakes the device
// - Three supply monitor flags are provided
// - Supply output off by enable bit, on by wake
// - Low auxiliary supply at power-up enters OFF
// - Register accesses ignored while OFF
// - Oscillator good releases reset and, outside OFF, starts clock
`default_nettype none
module csc_clock_supply (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Wake and band pins
	input wire logic powerOnInput,
	input wire logic [4:0] buttonInput,
	input wire logic bandSelectPin,
	// Analog monitors
	input wire logic oscillatorGoodIn,
	input wire logic logicSupplyAbove,
	input wire logic supplyOutAbove,
	input wire logic supplyOutBelowLow,
	input wire logic auxSupplyHigh,
	// Controller clock and reset
	output logic clkOut,
	output logic mcuReset_n,
	// Supply switches
	output logic supplyOutSwitch,
	output logic analogSupplySwitch,
	output logic logicSupplySwitch,
	// Timing enables
	output logic baseClockTick,
	output logic bitcheckTick,
	output logic baudTick,
	// Interrupt
	output logic irq
);
	import csc_pkg::*;

	function automatic logic [31:0] laneMerge(input logic [31:0] old,
		input logic [31:0] din, input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i])
				res[i*8 +: 8] = din[i*8 +: 8];
		end
		return res;
	endfunction

	// Synchronised pins
	logic [10:0] pinSync;
	csc_sync #(.WIDTH(11)) u_sync (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.d({powerOnInput, buttonInput, bandSelectPin, oscillatorGoodIn,
			logicSupplyAbove, supplyOutAbove, supplyOutBelowLow}),
		.q(pinSync)
	);
	logic auxSync;
	csc_sync #(.WIDTH(1)) u_sync_aux (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.d(auxSupplyHigh),
		.q(auxSync)
	);
	wire powerOn = pinSync[10];
	wire [4:0] buttons = pinSync[9:5];
	wire band433 = pinSync[4];
	wire oscGood = pinSync[3];
	wire logicGood = pinSync[2];
	wire supGood = pinSync[1];
	wire lowBatt = pinSync[0];

	// Registers
	csc_mode_e mode_r;
	logic [1:0] strapWait_r;
	logic strapDone_r;
	logic [3:0] ctrl_r;
	logic [8:0] tune_r;
	logic [1:0] baudRange_r;
	logic [5:0] bitLimit_r;
	logic [3:0] status_r;
	logic [3:0] mask_r;
	logic supplyOutOn_r;
	logic clkPhase_r;
	logic oscPrev_r;
	logic lowPrev_r;
	logic supPrev_r;
	logic [11:0] rfWord_r;
	logic [21:0] rfRatio_r;

	// Bus decode
	wire busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire isOff = (mode_r == CSC_OFF);
	wire busWr = busReq & wb_we_i & ~isOff;
	wire [31:0] wrCtrl = laneMerge({28'h0, ctrl_r}, wb_dat_i, wb_sel_i);
	wire [31:0] wrTune = laneMerge({23'h0, tune_r}, wb_dat_i, wb_sel_i);
	wire [31:0] wrBaud = laneMerge({24'h0, bitLimit_r, baudRange_r},
		wb_dat_i, wb_sel_i);
	wire [31:0] wrStat = laneMerge(32'h0, wb_dat_i, wb_sel_i);
	wire [31:0] wrMask = laneMerge({28'h0, mask_r}, wb_dat_i, wb_sel_i);
	wire selCtrl = busWr & (wb_adr_i == CSC_ADR_CTRL);
	wire selTune = busWr & (wb_adr_i == CSC_ADR_TUNE);
	wire selBaud = busWr & (wb_adr_i == CSC_ADR_BAUD);
	wire selStat = busWr & (wb_adr_i == CSC_ADR_STAT);
	wire selMask = busWr & (wb_adr_i == CSC_ADR_MASK);

	// Wake and OFF command
	wire wakeReq = powerOn | ~(&buttons);
	wire offCmd = selCtrl & wrCtrl[CSC_CTRL_OFFCMD] &
		~ctrl_r[CSC_CTRL_ANAEN] & ~powerOn & (&buttons);
	wire strapNow = ~strapDone_r & (strapWait_r == CSC_STRAP_WAIT);
	csc_mode_e modeNxt;
	assign modeNxt = strapNow ? (auxSync ? CSC_IDLE : CSC_OFF) :
		(isOff & strapDone_r & wakeReq) ? CSC_IDLE :
		offCmd ? CSC_OFF : mode_r;

	// Supply output enable: cleared by software, restored only by wake
	wire supplyOutNxt = (modeNxt == CSC_OFF) ? 1'b0 :
		(isOff | wakeReq) ? 1'b1 :
		(selCtrl & ~wrCtrl[CSC_CTRL_SUPEN]) ? 1'b0 : supplyOutOn_r;

	// Events, set wins over clear
	wire [3:0] events;
	assign events[CSC_ST_WAKE] = isOff & strapDone_r & wakeReq;
	assign events[CSC_ST_OSCGOOD] = oscGood & ~oscPrev_r;
	assign events[CSC_ST_LOWBATT] = lowBatt & ~lowPrev_r;
	assign events[CSC_ST_SUPLOST] = supPrev_r & ~supGood;
	wire [3:0] statClr = selStat ? wrStat[3:0] : 4'h0;
	wire [3:0] statusNxt = (status_r & ~statClr) | events;

	// Tuning word and RF ratio
	wire [11:0] partLow = {7'h0, tune_r[CSC_LOW_BITS-1:0]};
	wire [11:0] partHigh = {3'h0, tune_r[8:CSC_LOW_BITS], 5'h00};
	wire [11:0] wordNxt = 12'(CSC_TUNE_BASE + partLow + partHigh);
	wire [7:0] mult2 = ~band433 ? CSC_MULT2_868 :
		ctrl_r[CSC_CTRL_BAND315] ? CSC_MULT2_315 : CSC_MULT2_433;
	wire [21:0] ratioNxt = 22'({mult2, 14'h0000} + {9'h0, rfWord_r, 1'b0} +
		CSC_RATIO_OFS);
	wire wordInRange = (rfWord_r >= CSC_TUNE_MIN) &&
		(rfWord_r <= CSC_TUNE_MAX);

	// Clock dividers held in OFF mode and until oscillator good
	wire oscRun = oscGood & ~isOff;
	logic halfTick;
	csc_divider u_div_clk (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.hold(~oscRun),
		.advance(1'b1),
		.limit(CSC_CLK_HALF_LIM),
		.tick(halfTick)
	);
	csc_divider u_div_base (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.hold(~oscRun),
		.advance(1'b1),
		.limit(CSC_BASE_LIM),
		.tick(baseClockTick)
	);
	csc_divider u_div_bitcheck (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.hold(~oscRun),
		.advance(baseClockTick),
		.limit({6'h00, baudRange_r}),
		.tick(bitcheckTick)
	);
	csc_divider u_div_baud (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.hold(~oscRun),
		.advance(bitcheckTick),
		.limit({2'h0, bitLimit_r}),
		.tick(baudTick)
	);

	// Read mux
	wire [31:0] monWord = {25'h0, wordInRange, supplyOutOn_r, isOff,
		oscGood, lowBatt, supGood, logicGood};
	wire [31:0] rdData = isOff ? 32'h0 :
		(wb_adr_i == CSC_ADR_CTRL) ? {28'h0, ctrl_r} :
		(wb_adr_i == CSC_ADR_TUNE) ? {23'h0, tune_r} :
		(wb_adr_i == CSC_ADR_BAUD) ? {24'h0, bitLimit_r, baudRange_r} :
		(wb_adr_i == CSC_ADR_STAT) ? {28'h0, status_r} :
		(wb_adr_i == CSC_ADR_MASK) ? {28'h0, mask_r} :
		(wb_adr_i == CSC_ADR_MON) ? monWord :
		(wb_adr_i == CSC_ADR_WORD) ? {20'h0, rfWord_r} :
		(wb_adr_i == CSC_ADR_RATIO) ? {10'h0, rfRatio_r} : 32'h0;

	// Bus answer
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= busReq;
			wb_dat_o <= busReq ? rdData : 32'h0;
		end
	end

	// Mode and power-up strap
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			mode_r <= CSC_OFF;
			strapWait_r <= 2'h0;
			strapDone_r <= 1'b0;
		end else begin
			mode_r <= modeNxt;
			if (!strapDone_r)
				strapWait_r <= 2'(strapWait_r + 2'h1);
			if (strapNow)
				strapDone_r <= 1'b1;
		end
	end

	// Software registers
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			ctrl_r <= CSC_CTRL_RESET;
			tune_r <= CSC_TUNE_RESET;
			baudRange_r <= 2'h0;
			bitLimit_r <= 6'h00;
			mask_r <= 4'h0;
			status_r <= 4'h0;
		end else begin
			if (selCtrl)
				ctrl_r <= wrCtrl[3:0];
			if (selTune)
				tune_r <= wrTune[8:0];
			if (selBaud)
				{bitLimit_r, baudRange_r} <= wrBaud[7:0];
			if (selMask)
				mask_r <= wrMask[3:0];
			status_r <= statusNxt;
		end
	end

	// Derived state and outputs
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			supplyOutOn_r <= 1'b0;
			clkPhase_r <= 1'b0;
			oscPrev_r <= 1'b0;
			lowPrev_r <= 1'b0;
			supPrev_r <= 1'b0;
			rfWord_r <= CSC_TUNE_BASE;
			rfRatio_r <= 22'h0;
			clkOut <= 1'b0;
			mcuReset_n <= 1'b0;
			supplyOutSwitch <= 1'b0;
			analogSupplySwitch <= 1'b0;
			logicSupplySwitch <= 1'b0;
			irq <= 1'b0;
		end else begin
			supplyOutOn_r <= supplyOutNxt;
			clkPhase_r <= ~oscRun ? 1'b0 : clkPhase_r ^ halfTick;
			oscPrev_r <= oscGood;
			lowPrev_r <= lowBatt;
			supPrev_r <= supGood;
			rfWord_r <= wordNxt;
			rfRatio_r <= ratioNxt;
			clkOut <= clkPhase_r & ctrl_r[CSC_CTRL_CLKEN] & oscRun;
			mcuReset_n <= supGood & oscGood;
			supplyOutSwitch <= supplyOutOn_r & ~isOff;
			analogSupplySwitch <= ~isOff & ctrl_r[CSC_CTRL_ANAEN];
			logicSupplySwitch <= ~isOff;
			irq <= |(status_r & mask_r);
		end
	end

	// Checks wait until registered state has left reset
	logic [2:0] warm_r;
	always_ff @(posedge ref_clk) begin
		if (!reset_n)
			warm_r <= 3'h0;
		else
			warm_r <= {warm_r[1:0], 1'b1};
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n || !warm_r[2]);

	logic [5:0] baseGap_r;
	logic baseSeen_r;
	always_ff @(posedge ref_clk) begin
		if (!reset_n || !oscRun) begin
			baseGap_r <= 6'h00;
			baseSeen_r <= 1'b0;
		end else begin
			baseGap_r <= baseClockTick ? 6'h00 : 6'(baseGap_r + 6'h01);
			if (baseClockTick)
				baseSeen_r <= 1'b1;
		end
	end

	sequence s_runFour;
		oscRun [*4];
	endsequence

	a_clk_half_period: assert property (
		$rose(clkPhase_r) ##0 s_runFour |-> !clkPhase_r &&
		$past(clkPhase_r) && $past(clkPhase_r, 2))
		else $error("clock phase half period not three cycles");
	a_base_period: assert property (
		baseClockTick && baseSeen_r && $past(oscRun) |->
		baseGap_r == 6'h1f)
		else $error("base clock period wrong");
	a_bitcheck_from_base: assert property (
		bitcheckTick |-> $past(baseClockTick))
		else $error("bit-check tick without base tick");
	a_reset_low: assert property (
		!supGood |=> !mcuReset_n)
		else $error("controller reset not asserted");
	a_reset_release: assert property (
		supGood && oscGood |=> mcuReset_n)
		else $error("controller reset not released");
	a_off_ignore: assert property (
		isOff && busReq && wb_we_i |=> $stable(ctrl_r) && $stable(tune_r))
		else $error("register written while off");
	a_wake_idle: assert property (
		isOff && strapDone_r && wakeReq |=> mode_r == CSC_IDLE ##1
		supplyOutSwitch && logicSupplySwitch)
		else $error("wake did not power up");
	a_supply_clear: assert property (
		!isOff && selCtrl && !wrCtrl[CSC_CTRL_SUPEN] && !wakeReq |=>
		!supplyOutOn_r ##1 !supplyOutSwitch)
		else $error("supply output not switched off");
	a_strap_off: assert property (
		strapNow && !auxSync |=> isOff ##1 !logicSupplySwitch &&
		!supplyOutSwitch && !analogSupplySwitch)
		else $error("power-up did not enter off mode");
	a_ratio_band: assert property (
		$stable(tune_r) && $stable(mult2) [*3] |->
		rfRatio_r == 22'({mult2, 14'h0000} +
		{9'h0, 12'(CSC_TUNE_BASE + {3'h0, tune_r}), 1'b0} + CSC_RATIO_OFS))
		else $error("rf ratio mismatch");
endmodule
`default_nettype wire

// >>> sim/csc_mcu_model.sv
`default_nettype none
module csc_mcu_model (
	// Clock and reset from the device
	input wire logic ref_clk,
	input wire logic clkOut,
	input wire logic mcuReset_n,
	input wire logic watch,
	// Observations
	output int periods,
	output int badRuns
);
	timeunit 1ns;
	timeprecision 1ns;
	int runLen = 0;
	logic lastClk = 1'b0;
	logic seenEdge = 1'b0;
	initial begin
		periods = 0;
		badRuns = 0;
	end
	always @(posedge ref_clk) begin
		lastClk <= clkOut;
		if (!mcuReset_n || !watch) begin
			runLen <= 0;
			seenEdge <= 1'b0;
		end else if (clkOut !== lastClk) begin
			// First run may be short, so it is not judged
			if (seenEdge && runLen != 2) badRuns <= badRuns + 1;
			if (clkOut) periods <= periods + 1;
			seenEdge <= 1'b1;
			runLen <= 0;
		end else begin
			runLen <= runLen + 1;
		end
	end
endmodule
`default_nettype wire

// >>> sim/tb_csc_clock_supply.sv
`default_nettype none
module tb_csc_clock_supply;
	timeunit 1ns;
	timeprecision 1ns;
	import csc_pkg::*;
	logic ref_clk = 0, reset_n = 0, cyc = 0, stb = 0, we = 0, watch = 0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] datI = 32'h0, q;
	logic pwr = 0, band = 1, osc = 0, lgc = 0, sup = 0, low = 0, aux = 1;
	logic [4:0] btn = 5'h1f;
	wire logic [31:0] datO;
	wire logic ack, clkOut, mcuRst_n, supSw, anaSw, lgcSw;
	wire logic baseT, bitT, baudT, irq;
	int numErrors = 0, nTests = 0, periods, badRuns;
	always #50 ref_clk = ~ref_clk;
	csc_clock_supply i_dut (.ref_clk(ref_clk), .reset_n(reset_n),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack),
		.powerOnInput(pwr), .buttonInput(btn), .bandSelectPin(band),
		.oscillatorGoodIn(osc), .logicSupplyAbove(lgc),
		.supplyOutAbove(sup), .supplyOutBelowLow(low), .auxSupplyHigh(aux),
		.clkOut(clkOut), .mcuReset_n(mcuRst_n), .supplyOutSwitch(supSw),
		.analogSupplySwitch(anaSw), .logicSupplySwitch(lgcSw),
		.baseClockTick(baseT), .bitcheckTick(bitT), .baudTick(baudT),
		.irq(irq));
	csc_mcu_model i_mcu (.ref_clk(ref_clk), .clkOut(clkOut),
		.mcuReset_n(mcuRst_n), .watch(watch), .periods(periods),
		.badRuns(badRuns));
	task closeOut;
		$display("errors %0d comparisons %0d", numErrors, nTests);
		if (numErrors == 0 && nTests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		nTests++;
		if (got !== exp) begin
			numErrors++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task stop(input string m);
		numErrors++;
		$display("wrong value at %0t: timeout %s", $time, m);
		closeOut();
	endtask
	task idle(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hf;
		datI <= d;
		do begin
			@(posedge ref_clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20) stop("ack");
		q = datO;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task rchk(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] mk, input string m);
		wb(1'b0, a, 32'h0);
		chk(q & mk, e, m);
	endtask
	function automatic logic tk(input int w);
		return (w == 0) ? baseT : ((w == 1) ? bitT : baudT);
	endfunction
	task gap(input int w, input int exp, input string m);
		int n;
		for (int k = 0; k < 2; k++) begin
			n = 0;
			do begin
				@(posedge ref_clk);
				n++;
			end while (tk(w) !== 1'b1 && n < 1000);
			if (n >= 1000) stop(m);
		end
		chk(32'(n), 32'(exp), m);
	endtask
	initial begin
		logic [8:0] tv [4];
		logic [7:0] m2;
		int e;
		tv = '{9'h0da, 9'h0db, 9'h1d5, 9'h1d6};
		idle(6);
		reset_n <= 1'b1;
		idle(8);
		rchk(CSC_ADR_CTRL, 32'h3, 32'h1f, "ctrl reset");
		rchk(CSC_ADR_TUNE, 32'h0dd, 32'h1ff, "tune reset");
		rchk(CSC_ADR_WORD, 32'hedd, 32'hfff, "word reset");
		chk(32'(lgcSw), 32'h1, "power up on");
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			wb(1'b1, CSC_ADR_TUNE, 32'(tv[i]));
			e = int'(CSC_TUNE_BASE) + int'(tv[i]);
			rchk(CSC_ADR_WORD, 32'(e), 32'hfff, "word");
			rchk(CSC_ADR_MON, (i == 1 || i == 2) ? 32'h40 : 32'h0, 32'h40,
				"range");
			for (int b = 0; b < 3; b++) begin
				band <= (b != 1);
				wb(1'b1, CSC_ADR_CTRL, (b == 2) ? 32'hb : 32'h3);
				idle(4);
				m2 = (b == 0) ? CSC_MULT2_433 :
					((b == 1) ? CSC_MULT2_868 : CSC_MULT2_315);
				e = int'(m2) * 16384 + 2 * e + int'(CSC_RATIO_OFS);
				rchk(CSC_ADR_RATIO, 32'(e), 32'hffffffff, "ratio");
				e = int'(CSC_TUNE_BASE) + int'(tv[i]);
			end
		end
		$display("test tuning done");
		lgc <= 1'b1;
		sup <= 1'b1;
		osc <= 1'b1;
		watch <= 1'b1;
		idle(6);
		chk(32'(mcuRst_n), 32'h1, "reset release");
		rchk(CSC_ADR_STAT, 32'h2, 32'h2, "osc status");
		chk(32'(irq), 32'h0, "masked irq");
		gap(0, 32, "base period");
		wb(1'b1, CSC_ADR_BAUD, 32'h9);
		gap(1, 64, "bitcheck");
		gap(2, 192, "baud");
		chk(32'(badRuns), 32'h0, "clock shape");
		chk(32'(periods > 10), 32'h1, "clock runs");
		$display("test clocks done");
		low <= 1'b1;
		idle(4);
		rchk(CSC_ADR_MON, 32'hf, 32'hf, "monitors");
		wb(1'b1, CSC_ADR_MASK, 32'h8);
		sup <= 1'b0;
		idle(6);
		chk(32'(mcuRst_n), 32'h0, "low supply reset");
		chk(32'(irq), 32'h1, "irq set");
		sup <= 1'b1;
		idle(4);
		wb(1'b1, CSC_ADR_STAT, 32'hf);
		idle(2);
		chk(32'(irq), 32'h0, "irq clear");
		wb(1'b1, CSC_ADR_CTRL, 32'h7);
		idle(2);
		chk(32'(anaSw), 32'h1, "analog on");
		wb(1'b1, CSC_ADR_CTRL, 32'h1);
		idle(4);
		chk(32'(supSw), 32'h0, "supply off");
		wb(1'b1, CSC_ADR_CTRL, 32'h3);
		idle(4);
		chk(32'(supSw), 32'h0, "no soft enable");
		pwr <= 1'b1;
		idle(6);
		chk(32'(supSw), 32'h1, "wake enable");
		pwr <= 1'b0;
		watch <= 1'b0;
		$display("test supply done");
		for (int i = 0; i < 2; i++) begin
			wb(1'b1, CSC_ADR_STAT, 32'hf);
			idle(4);
			wb(1'b1, CSC_ADR_CTRL, 32'h13);
			idle(4);
			chk(32'(supSw), 32'h0, "off supply");
			rchk(CSC_ADR_TUNE, 32'h0, 32'hffffffff, "off read");
			wb(1'b1, CSC_ADR_TUNE, 32'h1ff);
			if (i == 0)
				btn <= 5'h1b;
			else
				pwr <= 1'b1;
			idle(6);
			btn <= 5'h1f;
			pwr <= 1'b0;
			idle(4);
			chk(32'(supSw), 32'h1, "wake");
			rchk(CSC_ADR_TUNE, 32'h1d6, 32'h1ff, "tune kept");
			rchk(CSC_ADR_STAT, 32'h1, 32'h1, "wake status");
		end
		$display("test off done");
		aux <= 1'b0;
		reset_n <= 1'b0;
		idle(6);
		reset_n <= 1'b1;
		idle(8);
		chk({supSw, anaSw, lgcSw}, 32'h0, "power up off");
		rchk(CSC_ADR_CTRL, 32'h0, 32'hff, "off ctrl");
		$display("test power up done");
		closeOut();
	end
endmodule
`default_nettype wire
